// ===== shared/mifd_cfg.svh
`ifndef MIFD_CFG_SVH
`define MIFD_CFG_SVH

// Width of one terminal assignment number.
`define MIFD_ASSIGN_W      8
// Default count of direct input terminals.
`define MIFD_DIRECT_N      8
// Count of remote input terminals.
`define MIFD_REMOTE_N      16

// Assignment numbers of the input functions.
`define MIFD_NUM_UNUSED    8'h00
`define MIFD_NUM_ALARM     8'h08
`define MIFD_NUM_NOTICE    8'h0e
`define MIFD_NUM_TOOL      8'h10
`define MIFD_NUM_TORQUE    8'h16
`define MIFD_NUM_EXTSTOP   8'h19
`define MIFD_NUM_RUN       8'h3a
`define MIFD_NUM_CTLA      8'h3b
`define MIFD_NUM_SEL0      8'h40
`define MIFD_NUM_SEL1      8'h41
`define MIFD_NUM_SEL2      8'h42
`define MIFD_NUM_MODE      8'h48
`define MIFD_NUM_HOLDFREE  8'h4a
`define MIFD_NUM_GEN0      8'h50
`define MIFD_NUM_GEN1      8'h51
`define MIFD_NUM_GEN2      8'h52
`define MIFD_NUM_GEN3      8'h53

// Count of internal functions.
`define MIFD_FN_N          17

`endif

// ===== shared/mifd_edge_if.sv
`timescale 1ns/1ns

interface mifd_edge_if #(parameter int W = 2);
    logic [W-1:0] level;
    logic [W-1:0] pulse;

    modport src (output level, input pulse);
    modport det (input level, output pulse);
endinterface : mifd_edge_if

// ===== shared/mifd_pkg.sv
`include "mifd_cfg.svh"

package mifd_pkg;

    // Index of each internal function in a function mask.
    typedef enum logic [4:0] {
        FN_ALARM_CLR  = 5'h00,
        FN_NOTICE_CLR = 5'h01,
        FN_TOOL_REL   = 5'h02,
        FN_TORQUE_CAP = 5'h03,
        FN_EXT_FAULT  = 5'h04,
        FN_FWD_RUN    = 5'h05,
        FN_CTL_A      = 5'h06,
        FN_SEL0       = 5'h07,
        FN_SEL1       = 5'h08,
        FN_SEL2       = 5'h09,
        FN_MODE_SEL   = 5'h0a,
        FN_HOLD_FREE  = 5'h0b,
        FN_GEN0       = 5'h0c,
        FN_GEN1       = 5'h0d,
        FN_GEN2       = 5'h0e,
        FN_GEN3       = 5'h0f,
        FN_SPARE      = 5'h10
    } mifd_fn_t;

    typedef logic [`MIFD_FN_N-1:0]     mifd_mask_t;
    typedef logic [`MIFD_ASSIGN_W-1:0] mifd_num_t;

endpackage : mifd_pkg

// ===== src/mifd_decoder.sv
`timescale 1ns/1ns
`include "mifd_cfg.svh"

// Summary of operation
// - Assignment zero drives no function.
// - Alarm clear on rising edge only.
// - Notice clear on rising edge only.
// - Tool limit released while function ON.
// - Torque cap enabled while function ON.
// - External stop fault when function OFF.
// - Motor runs while run function ON and control function OFF (default mode) or ON (three-wire mode).
// - Control function meaning follows input mode.
// - Three select bits choose operation data.
// - Default mode: mode bit chooses stop kind.
// - Three-wire mode: mode bit chooses direction.
// - Hold free releases electrical load holding.
// - General bits carry no motor action.
// - Unassigned tool or torque reads ON.
// - External stop refused on remote inputs.
// - Unassigned external stop reads ON.
// - Three-wire mode swaps run control roles.
// - Multiple terminals combine by OR, except tool and torque.
// - Tool and torque combine by AND.
// - Sixteen remote terminals, each with assignment.
module mifd_decoder #(
    parameter int DIRECT_N = `MIFD_DIRECT_N
) (
    // Clock and reset.
    input  wire logic                                   ref_clk,
    input  wire logic                                   srst,
    // Direct input terminals and their assignment numbers.
    input  wire logic [DIRECT_N-1:0]                    directState,
    input  wire mifd_pkg::mifd_num_t [DIRECT_N-1:0]     directAssign,
    // Remote input terminals and their assignment numbers.
    input  wire logic [`MIFD_REMOTE_N-1:0]              remoteState,
    input  wire mifd_pkg::mifd_num_t [`MIFD_REMOTE_N-1:0] remoteAssign,
    // Configuration.
    input  wire logic                                   threeWireMode,
    input  wire logic                                   loadHoldEnable,
    input  wire logic                                   shaftHeld,
    // Event pulses.
    output logic                                        alarmClearPulse,
    output logic                                        noticeClearPulse,
    // Control levels.
    output logic                                        toolLimitRelease,
    output logic                                        torqueCapEnable,
    output logic                                        externalStopFault,
    output logic                                        motorRun,
    output logic                                        motorReverse,
    output logic                                        instantStop,
    output logic [2:0]                                  dataSelect,
    output logic                                        holdRelease,
    output logic [3:0]                                  generalBits,
    // Status.
    output logic                                        remoteAssignRefused
);
    import mifd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Maps one assignment number to a function mask.
    function automatic mifd_mask_t decode_assign(input mifd_num_t num, input logic isRemote);
        mifd_mask_t m;
        m = '0;
        case (num)
            `MIFD_NUM_ALARM:    m[FN_ALARM_CLR]  = 1'b1;
            `MIFD_NUM_NOTICE:   m[FN_NOTICE_CLR] = 1'b1;
            `MIFD_NUM_TOOL:     m[FN_TOOL_REL]   = 1'b1;
            `MIFD_NUM_TORQUE:   m[FN_TORQUE_CAP] = 1'b1;
            `MIFD_NUM_EXTSTOP:  m[FN_EXT_FAULT]  = !isRemote;
            `MIFD_NUM_RUN:      m[FN_FWD_RUN]    = 1'b1;
            `MIFD_NUM_CTLA:     m[FN_CTL_A]      = 1'b1;
            `MIFD_NUM_SEL0:     m[FN_SEL0]       = 1'b1;
            `MIFD_NUM_SEL1:     m[FN_SEL1]       = 1'b1;
            `MIFD_NUM_SEL2:     m[FN_SEL2]       = 1'b1;
            `MIFD_NUM_MODE:     m[FN_MODE_SEL]   = 1'b1;
            `MIFD_NUM_HOLDFREE: m[FN_HOLD_FREE]  = 1'b1;
            `MIFD_NUM_GEN0:     m[FN_GEN0]       = 1'b1;
            `MIFD_NUM_GEN1:     m[FN_GEN1]       = 1'b1;
            `MIFD_NUM_GEN2:     m[FN_GEN2]       = 1'b1;
            `MIFD_NUM_GEN3:     m[FN_GEN3]       = 1'b1;
            default:            m                = '0;
        endcase
        return m;
    endfunction : decode_assign

    ////////////////////////////////////////////////////////////////////////////////
    // Combines all terminals into per-function OR, AND and assigned masks.
    mifd_mask_t anyOn;
    mifd_mask_t allOn;
    mifd_mask_t assigned;
    logic       refusedNow;

    always_comb begin
        mifd_mask_t m;
        m          = '0;
        anyOn      = '0;
        allOn      = '1;
        assigned   = '0;
        refusedNow = 1'b0;
        for (int i = 0; i < DIRECT_N; i++) begin
            m        = decode_assign(directAssign[i], 1'b0);
            assigned = assigned | m;
            anyOn    = anyOn | (m & {`MIFD_FN_N{directState[i]}});
            allOn    = allOn & (~m | {`MIFD_FN_N{directState[i]}});
        end
        for (int i = 0; i < `MIFD_REMOTE_N; i++) begin
            m          = decode_assign(remoteAssign[i], 1'b1);
            assigned   = assigned | m;
            anyOn      = anyOn | (m & {`MIFD_FN_N{remoteState[i]}});
            allOn      = allOn & (~m | {`MIFD_FN_N{remoteState[i]}});
            refusedNow = refusedNow | (remoteAssign[i] == `MIFD_NUM_EXTSTOP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Rising-edge detection for the two clear requests.
    mifd_edge_if #(.W(2)) clearEdge ();

    logic [1:0] clearLevel_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            clearLevel_ff <= 2'h0;
        end else begin
            clearLevel_ff <= {anyOn[FN_NOTICE_CLR], anyOn[FN_ALARM_CLR]};
        end
    end

    assign clearEdge.level = clearLevel_ff;

    mifd_edge u_clear_edge (
        .ref_clk (ref_clk),
        .srst    (srst),
        .edge_io (clearEdge.det)
    );

    assign alarmClearPulse  = clearEdge.pulse[0];
    assign noticeClearPulse = clearEdge.pulse[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Tool limit, torque cap and external stop levels.
    logic toolLimitRelease_ff;
    logic torqueCapEnable_ff;
    logic externalStopFault_ff;
    logic remoteAssignRefused_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            toolLimitRelease_ff <= 1'b1;
            torqueCapEnable_ff  <= 1'b1;
        end else begin
            toolLimitRelease_ff <= allOn[FN_TOOL_REL];
            torqueCapEnable_ff  <= allOn[FN_TORQUE_CAP];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            externalStopFault_ff <= 1'b0;
        end else begin
            externalStopFault_ff <= assigned[FN_EXT_FAULT] && !anyOn[FN_EXT_FAULT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            remoteAssignRefused_ff <= 1'b0;
        end else begin
            remoteAssignRefused_ff <= refusedNow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Run, direction and stop method.
    logic motorRun_ff;
    logic motorReverse_ff;
    logic instantStop_ff;
    logic nxt_motorRun;
    logic nxt_motorReverse;
    logic nxt_instantStop;

    always_comb begin
        if (threeWireMode) begin
            nxt_motorRun     = anyOn[FN_FWD_RUN] && anyOn[FN_CTL_A];
            nxt_motorReverse = !anyOn[FN_MODE_SEL];
            nxt_instantStop  = !anyOn[FN_CTL_A];
        end else begin
            nxt_motorRun     = anyOn[FN_FWD_RUN] ^ anyOn[FN_CTL_A];
            nxt_motorReverse = anyOn[FN_CTL_A] && !anyOn[FN_FWD_RUN];
            nxt_instantStop  = anyOn[FN_MODE_SEL];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            motorRun_ff     <= 1'b0;
            motorReverse_ff <= 1'b0;
            instantStop_ff  <= 1'b0;
        end else begin
            motorRun_ff     <= nxt_motorRun;
            motorReverse_ff <= nxt_motorReverse;
            instantStop_ff  <= nxt_instantStop;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data select, hold release and general bits.
    logic [2:0] dataSelect_ff;
    logic       holdRelease_ff;
    logic [3:0] generalBits_ff;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dataSelect_ff <= 3'h0;
        end else begin
            dataSelect_ff <= {anyOn[FN_SEL2], anyOn[FN_SEL1], anyOn[FN_SEL0]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            holdRelease_ff <= 1'b0;
        end else begin
            holdRelease_ff <= loadHoldEnable && shaftHeld && anyOn[FN_HOLD_FREE];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            generalBits_ff <= 4'h0;
        end else begin
            generalBits_ff <= {anyOn[FN_GEN3], anyOn[FN_GEN2],
                               anyOn[FN_GEN1], anyOn[FN_GEN0]};
        end
    end

    assign toolLimitRelease    = toolLimitRelease_ff;
    assign torqueCapEnable     = torqueCapEnable_ff;
    assign externalStopFault   = externalStopFault_ff;
    assign motorRun            = motorRun_ff;
    assign motorReverse        = motorReverse_ff;
    assign instantStop         = instantStop_ff;
    assign dataSelect          = dataSelect_ff;
    assign holdRelease         = holdRelease_ff;
    assign generalBits         = generalBits_ff;
    assign remoteAssignRefused = remoteAssignRefused_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the decoded outputs.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    a_unused_inert: assert property (
        (directAssign == '0 && remoteAssign == '0) |=>
            !motorRun && generalBits == 4'h0 && dataSelect == 3'h0 && toolLimitRelease)
        else $error("Unused terminals drove a function.");

    a_tool_unassigned: assert property (
        !assigned[FN_TOOL_REL] |=> toolLimitRelease)
        else $error("Unassigned tool release is not ON.");

    a_torque_all_on: assert property (
        (assigned[FN_TORQUE_CAP] && (anyOn[FN_TORQUE_CAP] != allOn[FN_TORQUE_CAP]))
            |=> !torqueCapEnable)
        else $error("Torque cap enabled with a terminal OFF.");

    a_ext_fault_raise: assert property (
        (assigned[FN_EXT_FAULT] && !anyOn[FN_EXT_FAULT]) |=> externalStopFault)
        else $error("External stop fault missed.");

    a_ext_unassigned: assert property (
        !assigned[FN_EXT_FAULT] |=> !externalStopFault)
        else $error("Fault raised with no external stop assigned.");

    a_remote_refused: assert property (
        (directAssign == '0) |=> !externalStopFault)
        else $error("Remote terminal drove external stop.");

    a_select_binary: assert property (
        $changed(anyOn[FN_SEL0]) && $stable(anyOn[FN_SEL2:FN_SEL1]) |=>
            (dataSelect[0] == $past(anyOn[FN_SEL0])) && $stable(dataSelect[2:1]))
        else $error("Select bit order wrong.");

    a_default_fwd: assert property (
        (!threeWireMode && anyOn[FN_FWD_RUN] && !anyOn[FN_CTL_A]) |=>
            motorRun && !motorReverse)
        else $error("Forward run not applied.");

    a_three_wire_dir: assert property (
        threeWireMode |=> (motorReverse == !$past(anyOn[FN_MODE_SEL])))
        else $error("Three-wire direction wrong.");

    a_stop_method: assert property (
        (!threeWireMode && anyOn[FN_MODE_SEL]) |=> instantStop)
        else $error("Instant stop not selected.");

    a_hold_gate: assert property (
        !loadHoldEnable |=> !holdRelease)
        else $error("Hold released without load holding.");

    a_alarm_edge: assert property (
        ($rose(clearLevel_ff[0]) && !$past(srst, 2)) |=> alarmClearPulse ##1 !alarmClearPulse)
        else $error("Alarm clear pulse wrong.");

endmodule : mifd_decoder

// ===== src/mifd_edge.sv
`timescale 1ns/1ns

module mifd_edge (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Level in, rising-edge pulse out.
    mifd_edge_if.det edge_io
);
    import mifd_pkg::*;

    logic [$bits(edge_io.level)-1:0] prev_ff;
    logic [$bits(edge_io.level)-1:0] pulse_ff;
    logic [1:0]                      armed_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // A level already ON when reset ends gives no pulse.
    // Two stages, since the level arrives one register after reset ends.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            armed_ff <= 2'h0;
        end else begin
            armed_ff <= {armed_ff[0], 1'b1};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prev_ff  <= '0;
            pulse_ff <= '0;
        end else begin
            prev_ff  <= edge_io.level;
            pulse_ff <= armed_ff[1] ? (edge_io.level & ~prev_ff) : '0;
        end
    end

    assign edge_io.pulse = pulse_ff;

    ////////////////////////////////////////////////////////////////////////////////
    a_edge_only: assert property (@(posedge ref_clk) disable iff (srst)
        (|pulse_ff) |-> $past(armed_ff[1]) &&
            (pulse_ff == ($past(edge_io.level) & ~$past(prev_ff))))
        else $error("Clear pulse without a rising level.");

    a_level_no_repeat: assert property (@(posedge ref_clk) disable iff (srst)
        (|pulse_ff) |=> ((pulse_ff & $past(pulse_ff)) == '0))
        else $error("Clear pulse repeated on a held level.");

endmodule : mifd_edge

// ===== verif/mifd_host.sv
`timescale 1ns/1ns
`include "mifd_cfg.svh"

module mifd_host #(
    parameter int DIRECT_N = `MIFD_DIRECT_N
) (
    // Clock.
    input  wire logic                                ref_clk,
    // Terminal levels and assignment numbers.
    output logic [DIRECT_N-1:0]                      directState,
    output mifd_pkg::mifd_num_t [DIRECT_N-1:0]       directAssign,
    output logic [`MIFD_REMOTE_N-1:0]                remoteState,
    output mifd_pkg::mifd_num_t [`MIFD_REMOTE_N-1:0] remoteAssign
);
    import mifd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        directState  = '0;
        directAssign = '0;
        remoteState  = '0;
        remoteAssign = '0;
    end

    // Sets one terminal just after a clock edge; a remote one only on request.
    task automatic put(input bit remote, input int idx, input mifd_num_t num, input logic on);
        @(posedge ref_clk);
        #1;
        if (remote) begin
            remoteAssign[idx] = num;
            remoteState[idx]  = on;
        end else begin
            directAssign[idx] = num;
            directState[idx]  = on;
        end
    endtask : put

    // Returns every terminal to unused and OFF.
    task automatic clear_all();
        @(posedge ref_clk);
        #1;
        directState  = '0;
        directAssign = '0;
        remoteState  = '0;
        remoteAssign = '0;
    endtask : clear_all
endmodule : mifd_host

// ===== verif/testbench.sv
`timescale 1ns/1ns
`include "mifd_cfg.svh"

module testbench;
    import mifd_pkg::*;

    logic                                    ref_clk;
    logic                                    srst;
    logic                                    threeWireMode;
    logic                                    loadHoldEnable;
    logic                                    shaftHeld;
    logic [`MIFD_DIRECT_N-1:0]               directState;
    mifd_num_t [`MIFD_DIRECT_N-1:0]          directAssign;
    logic [`MIFD_REMOTE_N-1:0]               remoteState;
    mifd_num_t [`MIFD_REMOTE_N-1:0]          remoteAssign;
    logic                                    alarmClearPulse;
    logic                                    noticeClearPulse;
    logic                                    toolLimitRelease;
    logic                                    torqueCapEnable;
    logic                                    externalStopFault;
    logic                                    motorRun;
    logic                                    motorReverse;
    logic                                    instantStop;
    logic [2:0]                              dataSelect;
    logic                                    holdRelease;
    logic [3:0]                              generalBits;
    logic                                    remoteAssignRefused;
    logic [15:0]                             allOuts;
    int                                      n_errors;
    int                                      n_checks;

    assign allOuts = {alarmClearPulse, noticeClearPulse, toolLimitRelease, torqueCapEnable,
                      externalStopFault, motorRun, motorReverse, instantStop, dataSelect,
                      holdRelease, generalBits};

    ////////////////////////////////////////////////////////////////////////////////

    mifd_host mifd_host_inst (
        .ref_clk      (ref_clk),
        .directState  (directState),
        .directAssign (directAssign),
        .remoteState  (remoteState),
        .remoteAssign (remoteAssign)
    );

    mifd_decoder mifd_decoder_inst (
        .ref_clk             (ref_clk),
        .srst                (srst),
        .directState         (directState),
        .directAssign        (directAssign),
        .remoteState         (remoteState),
        .remoteAssign        (remoteAssign),
        .threeWireMode       (threeWireMode),
        .loadHoldEnable      (loadHoldEnable),
        .shaftHeld           (shaftHeld),
        .alarmClearPulse     (alarmClearPulse),
        .noticeClearPulse    (noticeClearPulse),
        .toolLimitRelease    (toolLimitRelease),
        .torqueCapEnable     (torqueCapEnable),
        .externalStopFault   (externalStopFault),
        .motorRun            (motorRun),
        .motorReverse        (motorReverse),
        .instantStop         (instantStop),
        .dataSelect          (dataSelect),
        .holdRelease         (holdRelease),
        .generalBits         (generalBits),
        .remoteAssignRefused (remoteAssignRefused)
    );

    ////////////////////////////////////////////////////////////////////////////////

    always #4 ref_clk = ~ref_clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic cfg(input logic tw, input logic lh, input logic sh);
        @(posedge ref_clk);
        #1;
        threeWireMode  = tw;
        loadHoldEnable = lh;
        shaftHeld      = sh;
    endtask : cfg

    // Raises one clear terminal and expects exactly one pulse.
    task automatic pulse_chk(input bit remote, input int idx, input mifd_num_t num);
        logic [15:0] exp;
        exp = (num == `MIFD_NUM_ALARM) ? 16'h0002 : 16'h0001;
        mifd_host_inst.put(remote, idx, num, 1'b1);
        settle(2);
        chk(16'({alarmClearPulse, noticeClearPulse}), exp, "clear pulse");
        settle(1);
        chk(16'({alarmClearPulse, noticeClearPulse}), 16'h0000, "pulse end");
        settle(3);
        chk(16'({alarmClearPulse, noticeClearPulse}), 16'h0000, "level held");
        mifd_host_inst.put(remote, idx, num, 1'b0);
    endtask : pulse_chk

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        test_done();
    end

    initial begin
        logic [2:0] exp3;
        logic       a;
        logic       b;
        logic       c;
        ref_clk        = 1'b0;
        srst           = 1'b1;
        threeWireMode  = 1'b0;
        loadHoldEnable = 1'b0;
        shaftHeld      = 1'b0;
        n_errors       = 0;
        n_checks       = 0;
        repeat (10) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        settle(3);
        chk(allOuts, 16'h3000, "idle outputs");
        mifd_host_inst.put(1'b0, 0, `MIFD_NUM_UNUSED, 1'b1);
        mifd_host_inst.put(1'b1, 15, `MIFD_NUM_UNUSED, 1'b1);
        settle(4);
        chk(allOuts, 16'h3000, "unused terminals");
        pulse_chk(1'b1, 7, `MIFD_NUM_ALARM);
        pulse_chk(1'b1, 7, `MIFD_NUM_ALARM);
        pulse_chk(1'b0, 3, `MIFD_NUM_NOTICE);
        for (int k = 0; k < 2; k++) begin
            mifd_host_inst.put(1'b0, 1, k ? `MIFD_NUM_TORQUE : `MIFD_NUM_TOOL, 1'b1);
            mifd_host_inst.put(1'b1, 2, k ? `MIFD_NUM_TORQUE : `MIFD_NUM_TOOL, 1'b0);
            settle(2);
            chk(16'({toolLimitRelease, torqueCapEnable}), k ? 16'h2 : 16'h1, "one off");
            mifd_host_inst.put(1'b1, 2, k ? `MIFD_NUM_TORQUE : `MIFD_NUM_TOOL, 1'b1);
            settle(2);
            chk(16'({toolLimitRelease, torqueCapEnable}), 16'h3, "all on");
        end
        mifd_host_inst.put(1'b0, 4, `MIFD_NUM_EXTSTOP, 1'b0);
        settle(2);
        chk(16'(externalStopFault), 16'h1, "ext off");
        mifd_host_inst.put(1'b0, 4, `MIFD_NUM_EXTSTOP, 1'b1);
        settle(2);
        chk(16'(externalStopFault), 16'h0, "ext on");
        mifd_host_inst.put(1'b1, 9, `MIFD_NUM_EXTSTOP, 1'b1);
        mifd_host_inst.put(1'b0, 4, `MIFD_NUM_EXTSTOP, 1'b0);
        settle(2);
        chk(16'({externalStopFault, remoteAssignRefused}), 16'h3, "remote ext");
        mifd_host_inst.clear_all();
        settle(2);
        chk(allOuts, 16'h3000, "cleared");
        chk(16'(remoteAssignRefused), 16'h0, "refused gone");
        mifd_host_inst.put(1'b1, 9, `MIFD_NUM_EXTSTOP, 1'b0);
        settle(2);
        chk(16'({externalStopFault, remoteAssignRefused}), 16'h1, "remote only");
        mifd_host_inst.put(1'b0, 5, `MIFD_NUM_RUN, 1'b1);
        mifd_host_inst.put(1'b1, 15, `MIFD_NUM_RUN, 1'b0);
        settle(2);
        chk(16'(motorRun), 16'h1, "run or");
        mifd_host_inst.put(1'b0, 5, `MIFD_NUM_RUN, 1'b0);
        for (int tw = 0; tw < 2; tw++) begin
            cfg(tw[0], 1'b0, 1'b0);
            for (int i = 0; i < 8; i++) begin
                a = i[0];
                b = i[1];
                c = i[2];
                exp3 = tw ? {a & b, ~c, ~b} : {a ^ b, b & ~a, c};
                mifd_host_inst.put(1'b1, 15, `MIFD_NUM_RUN, a);
                mifd_host_inst.put(1'b1, 4, `MIFD_NUM_CTLA, b);
                mifd_host_inst.put(1'b1, 5, `MIFD_NUM_MODE, c);
                settle(2);
                chk(16'({motorRun, motorReverse, instantStop}), 16'(exp3), "run mode");
            end
        end
        cfg(1'b0, 1'b0, 1'b0);
        mifd_host_inst.clear_all();
        for (int v = 0; v < 8; v++) begin
            mifd_host_inst.put(1'b1, 0, `MIFD_NUM_SEL0, v[0]);
            mifd_host_inst.put(1'b1, 1, `MIFD_NUM_SEL1, v[1]);
            mifd_host_inst.put(1'b1, 2, `MIFD_NUM_SEL2, v[2]);
            settle(2);
            chk(16'(dataSelect), 16'(v), "data select");
        end
        mifd_host_inst.clear_all();
        for (int g = 0; g < 4; g++) begin
            mifd_host_inst.put(1'b0, 7, 8'(`MIFD_NUM_GEN0 + g), 1'b1);
            settle(2);
            chk(allOuts, 16'h3000 | 16'(1 << g), "general bit");
        end
        mifd_host_inst.put(1'b0, 2, `MIFD_NUM_HOLDFREE, 1'b1);
        for (int j = 0; j < 4; j++) begin
            cfg(1'b0, j[0], j[1]);
            settle(2);
            chk(16'(holdRelease), (j == 3) ? 16'h1 : 16'h0, "hold free");
        end
        mifd_host_inst.put(1'b0, 2, `MIFD_NUM_HOLDFREE, 1'b0);
        settle(2);
        chk(16'(holdRelease), 16'h0, "hold kept");
        test_done();
    end
endmodule : testbench
